// File: etm_pkg.sv
/*
 * shared constants and types of the compare-output timer
 * assumes an 8-bit register port and a single system clock
 */
package etm_pkg;

    ////////////////////////////////////////////////////////////////////
    // register port carrier
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    ////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [3:0] CNT_LO_OFS = 4'h0;
    localparam logic [3:0] CNT_HI_OFS = 4'h1;
    localparam logic [3:0] CMPA_LO_OFS = 4'h2;
    localparam logic [3:0] CMPA_HI_OFS = 4'h3;
    localparam logic [3:0] CMPB_LO_OFS = 4'h4;
    localparam logic [3:0] CMPB_HI_OFS = 4'h5;
    localparam logic [3:0] CTRL0_OFS = 4'h6;
    localparam logic [3:0] CTRL1_OFS = 4'h7;
    localparam logic [3:0] CTRL2_OFS = 4'h8;
    localparam logic [3:0] FLAG_OFS = 4'h9;

    ////////////////////////////////////////////////////////////////////
    // field positions
    localparam int ON_BIT = 3;
    localparam int PER_LSB = 0;
    localparam int MODE_LSB = 6;
    localparam int ACT_LSB = 4;
    localparam int INIT_BIT = 3;
    localparam int POL_BIT = 2;
    localparam int CCLR_BIT = 0;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_B_BIT = 1;
    localparam int FLAG_P_BIT = 2;

    ////////////////////////////////////////////////////////////////////
    // reset values and codes
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] HI_RST = 2'h0;
    localparam logic [9:0] CNT_RST = 10'h000;
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    ////////////////////////////////////////////////////////////////////
    // timer tick: system clock cycles per count
    localparam logic [7:0] TICK_DIV = 8'h04;

    // last count value before a period clear
    function automatic logic [9:0] period_top(input logic [2:0] per);
        period_top = {per, 7'h00} - 10'h001;
    endfunction

    // next pin level for a two-bit action code
    function automatic logic apply_action(input logic [1:0] act,
                                          input logic cur);
        unique case (act)
            ACT_NONE: apply_action = cur;
            ACT_LOW: apply_action = 1'b0;
            ACT_HIGH: apply_action = 1'b1;
            ACT_TOGGLE: apply_action = ~cur;
        endcase
    endfunction

endpackage

// File: enhanced_timer.sv
/*
 * compare match output timer: counter, compare a/b, period p,
 * match flags and output pins, behind an 8-bit register port
 * assumes one clock, synchronous active-low reset, and a master
 * that never overlaps read and write strobes
 */
// The implementer's own choices: the register offsets and the address-and-strobe port.
// Behaviour
// - counter readable as low byte and two-bit high byte, read only
// - bits 7 to 2 of every high byte read as zero
// - compare value a is a writable ten-bit low byte plus two bits
// - compare value b is a writable ten-bit low byte plus two bits
// - four modes picked by mode fields in control one and two
// - all mode bits zero selects compare match output mode
// - clear select low: period match clears; period zero wraps
// - clear select low: a and period flags both raised
// - clear select high: compare a match clears the counter
// - clear select high: period flag is never raised
// - pins change on a or b matches and on timer start, never on period
// - in compare match output mode, action fields drive pins high, low or toggled on match
// - action field zero leaves the pin unchanged
// - pin a follows only a matches, b pins only b matches
// - timer on rising edge returns pins to initial level
// - initial level bit selects the level before any match
// - polarity bit inverts pins, except in timer counter mode
`timescale 1ns/100ps
module enhanced_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input etm_pkg::reg_req_s req,
    output logic [7:0] rdata,
    // compare output pins
    output logic output_pin_a,
    output logic output_pin_b0,
    output logic output_pin_b1,
    output logic output_pin_b2
);
    import etm_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [9:0] cnt_r;
    logic [9:0] compare_value_a;
    logic [9:0] compare_value_b;
    logic timer_on;
    logic [2:0] period_field;
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic [1:0] action_a;
    logic [1:0] action_b;
    logic out_a_initial_level;
    logic out_a_polarity;
    logic out_b_initial_level;
    logic out_b_polarity;
    logic clear_source_sel;
    logic match_a_flag;
    logic match_b_flag;
    logic match_period_flag;
    logic on_d_r;
    logic [7:0] div_r;
    logic tick_r;
    logic st_a_r;
    logic st_b_r;
    logic [7:0] rdata_r;
    logic pin_a_r;
    logic pin_b0_r;
    logic pin_b1_r;
    logic pin_b2_r;

    ////////////////////////////////////////////////////////////////////
    // decode
    logic wr_cnt;
    logic wr_flag;
    logic cmp_mode;
    logic tc_mode;
    logic run_tick;
    logic on_rise;
    logic hit_a;
    logic hit_b;
    logic hit_p;
    logic clr_cnt;
    logic st_a_nxt;
    logic st_b_nxt;

    assign wr_cnt = req.wr;
    assign wr_flag = req.wr && (req.addr == FLAG_OFS);
    assign cmp_mode = (mode_a == MODE_COMPARE) &&
                      (mode_b == MODE_COMPARE);
    assign tc_mode = (mode_a == MODE_TIMER) && (mode_b == MODE_TIMER);
    assign run_tick = timer_on && tick_r;
    assign on_rise = timer_on && !on_d_r;
    assign hit_a = run_tick && (cnt_r == compare_value_a);
    assign hit_b = run_tick && (cnt_r == compare_value_b);
    // period top, zero period gives 1023 so the count wraps
    assign hit_p = run_tick && !clear_source_sel &&
                   (cnt_r == period_top(period_field));
    assign clr_cnt = clear_source_sel ? hit_a : hit_p;

    ////////////////////////////////////////////////////////////////////
    // tick divider
    always_ff @(posedge clk) begin
        if (!rstn) begin
            div_r <= BYTE_RST;
            tick_r <= 1'b0;
        end else if (div_r == TICK_DIV - 8'h01) begin
            div_r <= BYTE_RST;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 8'h01;
            tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counter
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_r <= CNT_RST;
        end else if (run_tick) begin
            if (clr_cnt) begin
                cnt_r <= CNT_RST;
            end else begin
                cnt_r <= cnt_r + 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            compare_value_a <= CNT_RST;
            compare_value_b <= CNT_RST;
        end else if (wr_cnt) begin
            unique case (req.addr)
                CMPA_LO_OFS: compare_value_a[7:0] <= req.wdata;
                CMPA_HI_OFS: compare_value_a[9:8] <= req.wdata[1:0];
                CMPB_LO_OFS: compare_value_b[7:0] <= req.wdata;
                CMPB_HI_OFS: compare_value_b[9:8] <= req.wdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer_on <= 1'b0;
            period_field <= 3'h0;
        end else if (wr_cnt && req.addr == CTRL0_OFS) begin
            timer_on <= req.wdata[ON_BIT];
            period_field <= req.wdata[PER_LSB +: 3];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mode_a <= HI_RST;
            action_a <= ACT_NONE;
            out_a_initial_level <= 1'b0;
            out_a_polarity <= 1'b0;
            clear_source_sel <= 1'b0;
        end else if (wr_cnt && req.addr == CTRL1_OFS) begin
            mode_a <= req.wdata[MODE_LSB +: 2];
            action_a <= req.wdata[ACT_LSB +: 2];
            out_a_initial_level <= req.wdata[INIT_BIT];
            out_a_polarity <= req.wdata[POL_BIT];
            clear_source_sel <= req.wdata[CCLR_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mode_b <= HI_RST;
            action_b <= ACT_NONE;
            out_b_initial_level <= 1'b0;
            out_b_polarity <= 1'b0;
        end else if (wr_cnt && req.addr == CTRL2_OFS) begin
            mode_b <= req.wdata[MODE_LSB +: 2];
            action_b <= req.wdata[ACT_LSB +: 2];
            out_b_initial_level <= req.wdata[INIT_BIT];
            out_b_polarity <= req.wdata[POL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // match flags, write one to clear, a new match wins
    always_ff @(posedge clk) begin
        if (!rstn) begin
            match_a_flag <= 1'b0;
            match_b_flag <= 1'b0;
            match_period_flag <= 1'b0;
        end else begin
            match_a_flag <= (cmp_mode || tc_mode) && hit_a ||
                            match_a_flag &&
                            !(wr_flag && req.wdata[FLAG_A_BIT]);
            match_b_flag <= (cmp_mode || tc_mode) && hit_b ||
                            match_b_flag &&
                            !(wr_flag && req.wdata[FLAG_B_BIT]);
            match_period_flag <= (cmp_mode || tc_mode) && hit_p ||
                                 match_period_flag &&
                                 !(wr_flag && req.wdata[FLAG_P_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin state, before polarity
    always_comb begin
        st_a_nxt = st_a_r;
        st_b_nxt = st_b_r;
        if (on_rise) begin
            st_a_nxt = out_a_initial_level;
            st_b_nxt = out_b_initial_level;
        end else if (cmp_mode) begin
            if (hit_a) begin
                st_a_nxt = apply_action(action_a, st_a_r);
            end
            if (hit_b) begin
                st_b_nxt = apply_action(action_b, st_b_r);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            on_d_r <= 1'b0;
            st_a_r <= 1'b0;
            st_b_r <= 1'b0;
        end else begin
            on_d_r <= timer_on;
            st_a_r <= st_a_nxt;
            st_b_r <= st_b_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_a_r <= 1'b0;
            pin_b0_r <= 1'b0;
            pin_b1_r <= 1'b0;
            pin_b2_r <= 1'b0;
        end else begin
            pin_a_r <= st_a_nxt ^ (out_a_polarity && !tc_mode);
            pin_b0_r <= st_b_nxt ^ (out_b_polarity && !tc_mode);
            pin_b1_r <= st_b_nxt ^ (out_b_polarity && !tc_mode);
            pin_b2_r <= st_b_nxt ^ (out_b_polarity && !tc_mode);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read port, data in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_r <= BYTE_RST;
        end else if (req.rd) begin
            unique case (req.addr)
                CNT_LO_OFS: rdata_r <= cnt_r[7:0];
                CNT_HI_OFS: rdata_r <= {6'h00, cnt_r[9:8]};
                CMPA_LO_OFS: rdata_r <= compare_value_a[7:0];
                CMPA_HI_OFS: rdata_r <= {6'h00, compare_value_a[9:8]};
                CMPB_LO_OFS: rdata_r <= compare_value_b[7:0];
                CMPB_HI_OFS: rdata_r <= {6'h00, compare_value_b[9:8]};
                CTRL0_OFS: rdata_r <= {4'h0, timer_on, period_field};
                CTRL1_OFS: rdata_r <= {mode_a, action_a, out_a_initial_level,
                                       out_a_polarity, 1'b0, clear_source_sel};
                CTRL2_OFS: rdata_r <= {mode_b, action_b, out_b_initial_level,
                                       out_b_polarity, 2'h0};
                FLAG_OFS: rdata_r <= {5'h00, match_period_flag, match_b_flag,
                                      match_a_flag};
                default: rdata_r <= BYTE_RST;
            endcase
        end else begin
            rdata_r <= BYTE_RST;
        end
    end

    assign rdata = rdata_r;
    assign output_pin_a = pin_a_r;
    assign output_pin_b0 = pin_b0_r;
    assign output_pin_b1 = pin_b1_r;
    assign output_pin_b2 = pin_b2_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_cnt_read;
        @(posedge clk) disable iff (!rstn)
        req.rd && req.addr == CNT_LO_OFS |=> rdata == $past(cnt_r[7:0]);
    endproperty
    a_cnt_read: assert property (p_cnt_read)
        else $error("counter low byte read wrong");

    property p_hi_zero;
        @(posedge clk) disable iff (!rstn)
        req.rd && (req.addr == CNT_HI_OFS || req.addr == CMPA_HI_OFS ||
                   req.addr == CMPB_HI_OFS) |=> rdata[7:2] == 6'h00;
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("high byte upper bits not zero");

    property p_cmpa_write;
        @(posedge clk) disable iff (!rstn)
        req.wr && req.addr == CMPA_LO_OFS ##1 req.rd &&
        req.addr == CMPA_LO_OFS |=> rdata == $past(req.wdata, 2);
    endproperty
    a_cmpa_write: assert property (p_cmpa_write)
        else $error("compare a low byte not kept");

    property p_cmpb_write;
        @(posedge clk) disable iff (!rstn)
        req.wr && req.addr == CMPB_HI_OFS |=>
        compare_value_b[9:8] == $past(req.wdata[1:0]);
    endproperty
    a_cmpb_write: assert property (p_cmpb_write)
        else $error("compare b high bits not kept");

    property p_period_clear;
        @(posedge clk) disable iff (!rstn)
        run_tick && !clear_source_sel &&
        cnt_r == period_top(period_field) |=> cnt_r == CNT_RST;
    endproperty
    a_period_clear: assert property (p_period_clear)
        else $error("period match did not clear counter");

    property p_a_clear;
        @(posedge clk) disable iff (!rstn)
        run_tick && clear_source_sel && cnt_r == compare_value_a
        |=> cnt_r == CNT_RST;
    endproperty
    a_a_clear: assert property (p_a_clear)
        else $error("compare a match did not clear counter");

    property p_no_period_flag;
        @(posedge clk) disable iff (!rstn)
        clear_source_sel && !match_period_flag |=> !match_period_flag;
    endproperty
    a_no_period_flag: assert property (p_no_period_flag)
        else $error("period flag raised with clear select high");

    property p_act_none;
        @(posedge clk) disable iff (!rstn)
        action_a == ACT_NONE && !on_rise |=> st_a_r == $past(st_a_r);
    endproperty
    a_act_none: assert property (p_act_none)
        else $error("pin a changed with action none");

    sequence s_init_state;
        st_a_r == $past(out_a_initial_level);
    endsequence
    sequence s_init_pin;
        output_pin_a == $past(out_a_initial_level) ^
                        $past(out_a_polarity && !tc_mode);
    endsequence
    property p_on_rise;
        @(posedge clk) disable iff (!rstn)
        on_rise |=> s_init_state ##0 s_init_pin;
    endproperty
    a_on_rise: assert property (p_on_rise)
        else $error("pin not at initial level after start");

    property p_flag_hold;
        @(posedge clk) disable iff (!rstn)
        match_a_flag && !(wr_flag && req.wdata[FLAG_A_BIT])
        |=> match_a_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag a lost without clear");

    property p_count_up;
        @(posedge clk) disable iff (!rstn)
        run_tick && !clr_cnt |=> cnt_r == $past(cnt_r) + 10'h001;
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("counter did not advance on tick");

endmodule

// File: pin_watch.sv
/*
 * far-side model: circuitry fed by the compare output pins
 * assumes pins are registered levels in the clk domain
 */
`timescale 1ns/100ps
module pin_watch (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // compare output pins
    input wire logic pin_a,
    input wire logic pin_b0,
    input wire logic pin_b1,
    input wire logic pin_b2,
    // observations
    output logic [7:0] edges_a,
    output logic [7:0] edges_b,
    output logic b_split
);
    logic prev_a_r;
    logic prev_b_r;

    ////////////////////////////////////////////////////////////////////
    // level changes seen on pin a and pin b0
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev_a_r <= 1'b0;
            prev_b_r <= 1'b0;
            edges_a <= 8'h00;
            edges_b <= 8'h00;
        end else begin
            prev_a_r <= pin_a;
            prev_b_r <= pin_b0;
            edges_a <= edges_a + {7'h00, pin_a ^ prev_a_r};
            edges_b <= edges_b + {7'h00, pin_b0 ^ prev_b_r};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sticky mark when the three b pins disagree
    always_ff @(posedge clk) begin
        if (!rstn) begin
            b_split <= 1'b0;
        end else if ((pin_b0 !== pin_b1) || (pin_b0 !== pin_b2)) begin
            b_split <= 1'b1;
        end
    end
endmodule

// File: testbench.sv
/*
 * self-checking bench for the compare-output timer
 * assumes the register port and pin_watch far-side model
 */
`timescale 1ns/100ps
module testbench;
    import etm_pkg::*;
    logic clk;
    logic rstn;
    reg_req_s req;
    logic [7:0] rdata;
    logic pin_a, pin_b0, pin_b1, pin_b2, b_split;
    logic [7:0] edges_a, edges_b, snap_a, snap_b, d, exp_f;
    int err_total, n_compared, i, m;

    enhanced_timer u_enhanced_timer (.clk(clk), .rstn(rstn), .req(req),
        .rdata(rdata), .output_pin_a(pin_a), .output_pin_b0(pin_b0),
        .output_pin_b1(pin_b1), .output_pin_b2(pin_b2));
    pin_watch u_pin_watch (.clk(clk), .rstn(rstn), .pin_a(pin_a),
        .pin_b0(pin_b0), .pin_b1(pin_b1), .pin_b2(pin_b2),
        .edges_a(edges_a), .edges_b(edges_b), .b_split(b_split));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    // bus tasks and checks
    task automatic close_out;
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [9:0] seen,
                       input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= v;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask

    // write then read the same byte with no gap between strobes
    task automatic wr_rd(input string nm, input logic [3:0] a,
                         input logic [7:0] v);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= v;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(nm, {2'b00, rdata}, {2'b00, v});
    endtask

    task automatic rdc(input string nm, input logic [3:0] a,
                       input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(nm, {2'b00, v}, {2'b00, exp});
    endtask

    task automatic wait_flag(input logic [7:0] mask, input int bound);
        int k;
        k = 0;
        rd(FLAG_OFS, d);
        while ((d & mask) !== mask && k < bound) begin
            rd(FLAG_OFS, d);
            k++;
        end
        if ((d & mask) !== mask) begin
            err_total++;
            $display("mismatch flag wait exp %h seen %h", mask, d);
            close_out();
        end
    endtask

    task automatic stop_clear;
        wr(CTRL0_OFS, 8'h00);
        wr(FLAG_OFS, 8'h07);
        rdc("flags cleared", FLAG_OFS, 8'h00);
    endtask

    task automatic pins_now(input string nm, input logic a, input logic b);
        repeat (2) @(posedge clk);
        #1;
        chk({nm, " pin a"}, {9'h000, pin_a}, {9'h000, a});
        chk({nm, " pin b"}, {9'h000, pin_b0}, {9'h000, b});
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rstn = 1'b0;
        req = '0;
        err_total = 0;
        n_compared = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 11; i++)
            rdc("reset value", i[3:0], 8'h00);
        wr_rd("compare a back to back", CMPA_LO_OFS, 8'hA5);
        wr(CMPA_HI_OFS, 8'hFF);
        wr(CMPB_LO_OFS, 8'h5A);
        wr(CMPB_HI_OFS, 8'hFE);
        wr(CNT_LO_OFS, 8'h77);
        wr(4'hA, 8'h3C);
        rdc("compare a lo", CMPA_LO_OFS, 8'hA5);
        rdc("compare a hi", CMPA_HI_OFS, 8'h03);
        rdc("compare b lo", CMPB_LO_OFS, 8'h5A);
        rdc("compare b hi", CMPB_HI_OFS, 8'h02);
        rdc("counter lo ro", CNT_LO_OFS, 8'h00);
        rdc("counter hi ro", CNT_HI_OFS, 8'h00);
        rdc("unmapped", 4'hA, 8'h00);
        // each mode, both mode fields set alike
        wr(CMPA_LO_OFS, 8'h05);
        wr(CMPA_HI_OFS, 8'h00);
        wr(CMPB_LO_OFS, 8'h03);
        wr(CMPB_HI_OFS, 8'h00);
        for (m = 0; m < 4; m++) begin
            wr(CTRL1_OFS, {m[1:0], 6'h31});
            wr(CTRL2_OFS, {m[1:0], 6'h30});
            wr(CTRL0_OFS, 8'h08);
            pins_now("timer start", 1'b0, 1'b0);
            snap_a = edges_a;
            snap_b = edges_b;
            repeat (60) @(posedge clk);
            wr(CTRL0_OFS, 8'h00);
            exp_f = (m == 0 || m == 3) ? 8'h03 : 8'h00;
            rdc("mode flags", FLAG_OFS, exp_f);
            chk("pin a moved", {9'h000, edges_a != snap_a}, {9'h000, m == 0});
            chk("pin b moved", {9'h000, edges_b != snap_b}, {9'h000, m == 0});
            if (m == 0) begin
                rd(CNT_LO_OFS, d);
                chk("counter bound", {9'h000, d <= 8'h05}, 10'h001);
                chk("counter ran", {9'h000, d != 8'h00}, 10'h001);
                rdc("flags held", FLAG_OFS, 8'h03);
            end
            stop_clear();
        end
        chk("b pins alike", {9'h000, b_split}, 10'h000);
        // initial levels, polarity, no-action and b never matching
        wr(CMPB_LO_OFS, 8'hFF);
        wr(CMPB_HI_OFS, 8'h03);
        wr(CTRL1_OFS, 8'h09);
        wr(CTRL2_OFS, 8'h34);
        wr(CTRL0_OFS, 8'h08);
        pins_now("initial", 1'b1, 1'b1);
        repeat (60) @(posedge clk);
        pins_now("held", 1'b1, 1'b1);
        rdc("a only flag", FLAG_OFS, 8'h01);
        stop_clear();
        // period clear, p flag leaves pins alone
        wr(CMPA_LO_OFS, 8'h00);
        wr(CMPA_HI_OFS, 8'h02);
        wr(CTRL1_OFS, 8'h30);
        wr(CTRL2_OFS, 8'h00);
        wr(CTRL0_OFS, 8'h09);
        wait_flag(8'h04, 400);
        pins_now("p match", 1'b0, 1'b0);
        rdc("p only flag", FLAG_OFS, 8'h04);
        rdc("period cleared", CNT_HI_OFS, 8'h00);
        wr(CMPA_LO_OFS, 8'h0A);
        wr(CMPA_HI_OFS, 8'h00);
        wait_flag(8'h01, 400);
        rdc("a and p flags", FLAG_OFS, 8'h05);
        stop_clear();
        // period zero lets the counter wrap at overflow
        wr(CMPA_HI_OFS, 8'h03);
        wr(CTRL0_OFS, 8'h08);
        wait_flag(8'h04, 2500);
        rdc("wrapped", CNT_HI_OFS, 8'h00);
        stop_clear();
        // forced high on a, forced low on b
        wr(CMPA_LO_OFS, 8'h05);
        wr(CMPA_HI_OFS, 8'h00);
        wr(CMPB_LO_OFS, 8'h03);
        wr(CMPB_HI_OFS, 8'h00);
        wr(CTRL1_OFS, 8'h21);
        wr(CTRL2_OFS, 8'h18);
        wr(CTRL0_OFS, 8'h08);
        repeat (60) @(posedge clk);
        pins_now("forced", 1'b1, 1'b0);
        rdc("forced flags", FLAG_OFS, 8'h03);
        stop_clear();
        close_out();
    end
endmodule
